// [inc/lct_regs.svh]
// Register offsets, field positions and timing counts for the link cycle timer control
// Operation
// (R01) Reserved bits 31-23, 19-11 and 8-0 of link control read as zero.
// (R02) Source flag set: external rollover input events roll the cycle timer over.
// (R03) Source flag clear: roll over after 3072 ticks of 24.576 MHz, 125 us.
// (R04) Generator flag plus root: emit cycle start packet at every rollover.
// (R05) Generator flag clear: received cycle start packets resynchronise the timer.
// (R06) Overlong cycle event rising clears the generator flag in hardware.
// (R07) Setting the generator flag is ignored while overlong event stays set.
// (R08) Counting flag set: offset advances each 24.576 MHz period and rolls over.
// (R09) Counting flag clear: offset holds without counting.
// (R10) PHY packet flag plus enabled request context: deliver PHY packets there.
// (R11) PHY packet flag has no influence on identity packet acceptance.
// (R12) Identity packet flag alone decides acceptance of self-ID packets.
// (R13) Software loads a valid identity buffer pointer before setting that flag.
// (R14) Ones written to set alias set, to clear alias clear; reads return flags.
`ifndef LCT_REGS_SVH
`define LCT_REGS_SVH

`define LCT_ADDR_W 8
`define LCT_SET_OFFSET 8'hE0
`define LCT_CLR_OFFSET 8'hE4

`define LCT_BIT_SOURCE 22
`define LCT_BIT_GENERATOR 21
`define LCT_BIT_COUNTING 20
`define LCT_BIT_PHY_RX 10
`define LCT_BIT_IDENT_RX 9
`define LCT_FLAG_MASK 32'h0070_0600
`define LCT_RESET_VALUE 32'h0000_0000

`define LCT_REF_CLK_KHZ 100000
`define LCT_TICK_KHZ 24576
`define LCT_CYCLE_US 125
`define LCT_TICKS_PER_CYCLE (`LCT_TICK_KHZ * `LCT_CYCLE_US / 1000)
`define LCT_OFFSET_W 12
`define LCT_COUNT_W 13
`define LCT_ACC_W 17

`endif

// [inc/lct_pkg.sv]
// Types shared by the link cycle timer control block
package lct_pkg;
   typedef logic [11:0] lct_offset_t;
   typedef logic [12:0] lct_count_t;
   typedef logic [31:0] lct_word_t;
endpackage

// [hdl/lct_link_control.sv]
// Link control flags, cycle timer and packet acceptance gating
`include "lct_regs.svh"
module lct_link_control
   import lct_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [`LCT_ADDR_W-1:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [31:0] reg_wr_data,
   input wire logic reg_rd_en,
   output logic [31:0] reg_rd_data,
   input wire logic external_rollover_input,
   input wire logic phy_is_root,
   input wire logic overlong_cycle_event,
   input wire logic rx_cycle_start_valid,
   input wire logic [`LCT_OFFSET_W-1:0] rx_cycle_start_offset,
   input wire logic [`LCT_COUNT_W-1:0] rx_cycle_start_count,
   input wire logic rx_phy_packet_valid,
   input wire logic ar_request_context_enabled,
   input wire logic rx_identity_packet_valid,
   output logic cycle_start_emit,
   output logic phy_packet_deliver,
   output logic identity_packet_accept,
   output logic [`LCT_OFFSET_W-1:0] cycle_timer_offset,
   output logic [`LCT_COUNT_W-1:0] cycle_timer_count
);

   // Overview of the block
   // Five control flags live here, each one bit wide
   // Rollover source: internal tick count or the external pin
   // Cycle start generator: emits a start pulse at each rollover while the PHY reports root
   // Offset counting: gates offset steps and rollovers; resync loads still pass
   // PHY packet receive: opens the gate to the request context
   // Identity packet receive: opens the gate for self-ID traffic
   //
   // Register access
   // Two aliases share one flag image
   // A write to the set alias ORs ones into the flags
   // A write to the clear alias removes the flags given as ones
   // Zeros in either write leave the flags untouched
   // Reads from either alias return the same image
   // Reads elsewhere return zero so stale data never leaks
   // Read data is registered and stands until the next read
   //
   // Timer
   // The tick comes from a fractional accumulator on the 100 MHz clock
   // Ticks are therefore jittery by one clock but exact on average
   // One cycle of 3072 ticks is exactly 12500 reference clocks
   // Internal mode wraps the offset at the last tick of the cycle
   // External mode waits for a pin edge and saturates meanwhile
   // Saturation avoids a false short cycle if the pin stalls
   // The count field advances once per rollover and wraps freely
   //
   // Resync
   // A received cycle start overwrites offset and count directly
   // Only honoured while this node is not generating starts
   // It wins over a same-cycle local step, the sender is authoritative
   //
   // Overlong cycle event
   // Its rising edge drops the generator flag by hardware
   // While the event level stays high, setting that flag is refused
   // The edge is taken on the raw level, the input is on this clock
   //
   // Limitations
   // No interrupt is raised here; the event register lives elsewhere
   // The buffer pointer check for identity packets is software's job
   // All outputs are registered, so each answer trails by one clock

   localparam logic [`LCT_ACC_W-1:0] TICK_STEP = (`LCT_ACC_W)'(`LCT_TICK_KHZ);
   localparam logic [`LCT_ACC_W-1:0] TICK_MOD = (`LCT_ACC_W)'(`LCT_REF_CLK_KHZ);
   localparam lct_offset_t LAST_OFFSET = 12'(`LCT_TICKS_PER_CYCLE - 1);
   localparam lct_offset_t MAX_OFFSET = 12'hFFF;

   logic rollover_source_select_ff, nxt_rollover_source_select;
   logic cycle_start_generator_enable_ff, nxt_cycle_start_generator_enable;
   logic offset_counting_enable_ff, nxt_offset_counting_enable;
   logic phy_packet_receive_enable_ff, nxt_phy_packet_receive_enable;
   logic identity_packet_receive_enable_ff, nxt_identity_packet_receive_enable;
   logic overlong_prev_ff;
   logic [2:0] ext_sync_ff;
   logic ext_level_ff, nxt_ext_level;
   logic [`LCT_ACC_W-1:0] tick_acc_ff, nxt_tick_acc;
   lct_offset_t offset_ff, nxt_offset;
   lct_count_t count_ff, nxt_count;
   logic emit_ff, nxt_emit;
   logic phy_deliver_ff, nxt_phy_deliver;
   logic ident_accept_ff, nxt_ident_accept;
   lct_word_t rd_data_ff, nxt_rd_data;
   lct_word_t flags_word;
   logic set_wr, clr_wr, tick, ext_event, overlong_rise, rollover;

   // Flag image; every bit outside the five flags reads zero
   always_comb
   begin
      flags_word = `LCT_RESET_VALUE; // [R01]
      flags_word[`LCT_BIT_SOURCE] = rollover_source_select_ff;
      flags_word[`LCT_BIT_GENERATOR] = cycle_start_generator_enable_ff;
      flags_word[`LCT_BIT_COUNTING] = offset_counting_enable_ff;
      flags_word[`LCT_BIT_PHY_RX] = phy_packet_receive_enable_ff;
      flags_word[`LCT_BIT_IDENT_RX] = identity_packet_receive_enable_ff;
   end

   assign set_wr = reg_wr_en && (reg_addr == `LCT_SET_OFFSET);
   assign clr_wr = reg_wr_en && (reg_addr == `LCT_CLR_OFFSET);
   assign overlong_rise = overlong_cycle_event && !overlong_prev_ff;

   // Set and clear aliases; zeros written leave flags alone
   always_comb
   begin
      nxt_rollover_source_select = rollover_source_select_ff;
      nxt_offset_counting_enable = offset_counting_enable_ff;
      nxt_phy_packet_receive_enable = phy_packet_receive_enable_ff;
      nxt_identity_packet_receive_enable = identity_packet_receive_enable_ff;
      nxt_cycle_start_generator_enable = cycle_start_generator_enable_ff;
      if (set_wr)
      begin
         nxt_rollover_source_select |= reg_wr_data[`LCT_BIT_SOURCE]; // [R14]
         nxt_offset_counting_enable |= reg_wr_data[`LCT_BIT_COUNTING]; // [R14]
         nxt_phy_packet_receive_enable |= reg_wr_data[`LCT_BIT_PHY_RX]; // [R14]
         nxt_identity_packet_receive_enable |= reg_wr_data[`LCT_BIT_IDENT_RX]; // [R14]
         // Set refused while the overlong event is still pending
         if (!overlong_cycle_event)
         begin
            nxt_cycle_start_generator_enable |= reg_wr_data[`LCT_BIT_GENERATOR]; // [R07]
         end
      end
      if (clr_wr)
      begin
         nxt_rollover_source_select &= ~reg_wr_data[`LCT_BIT_SOURCE]; // [R14]
         nxt_offset_counting_enable &= ~reg_wr_data[`LCT_BIT_COUNTING]; // [R14]
         nxt_phy_packet_receive_enable &= ~reg_wr_data[`LCT_BIT_PHY_RX]; // [R14]
         nxt_identity_packet_receive_enable &= ~reg_wr_data[`LCT_BIT_IDENT_RX]; // [R14]
         nxt_cycle_start_generator_enable &= ~reg_wr_data[`LCT_BIT_GENERATOR]; // [R14]
      end
      // Hardware clear on the overlong event edge
      if (overlong_rise)
      begin
         nxt_cycle_start_generator_enable = 1'b0; // [R06]
      end
   end

   // Registered read; unmapped addresses return zero
   always_comb
   begin
      nxt_rd_data = rd_data_ff;
      if (reg_rd_en)
      begin
         if (reg_addr == `LCT_SET_OFFSET || reg_addr == `LCT_CLR_OFFSET)
         begin
            nxt_rd_data = flags_word; // [R14]
         end
         else
         begin
            nxt_rd_data = `LCT_RESET_VALUE;
         end
      end
   end

   // Fractional accumulator makes 24.576 MHz ticks from the 100 MHz clock
   // Adds the tick rate each clock and subtracts the clock rate on wrap
   // Avoids a second clock domain at the cost of one clock of jitter
   // Ticks never fall on two neighbouring clocks at this ratio
   always_comb
   begin
      tick = (tick_acc_ff + TICK_STEP) >= TICK_MOD;
      if (tick)
      begin
         nxt_tick_acc = tick_acc_ff + TICK_STEP - TICK_MOD;
      end
      else
      begin
         nxt_tick_acc = tick_acc_ff + TICK_STEP;
      end
   end

   // Pin event counts once the second and third stages agree
   // A glitch shorter than two clocks never reaches the timer
   // The event is the rising edge of the filtered level only
   always_comb
   begin
      nxt_ext_level = ext_level_ff;
      if (ext_sync_ff[1] == ext_sync_ff[2])
      begin
         nxt_ext_level = ext_sync_ff[2];
      end
      ext_event = nxt_ext_level && !ext_level_ff;
   end

   // Cycle timer: counting gate, rollover source, resync from received starts
   // Rollover is evaluated only while counting is enabled
   // The emit pulse follows the rollover by one clock
   // Root status is sampled at the rollover clock itself
   always_comb
   begin
      nxt_offset = offset_ff;
      nxt_count = count_ff;
      rollover = 1'b0;
      if (offset_counting_enable_ff) // [R08] [R09]
      begin
         if (rollover_source_select_ff)
         begin
            rollover = ext_event; // [R02]
         end
         else
         begin
            rollover = tick && (offset_ff == LAST_OFFSET); // [R03]
         end
         if (rollover)
         begin
            nxt_offset = '0;
            nxt_count = count_ff + 13'h0001;
         end
         // External mode saturates rather than wrapping between strobes
         else if (tick && offset_ff != MAX_OFFSET)
         begin
            nxt_offset = offset_ff + 12'h001; // [R08]
         end
      end
      if (!cycle_start_generator_enable_ff && rx_cycle_start_valid)
      begin
         nxt_offset = rx_cycle_start_offset; // [R05]
         nxt_count = rx_cycle_start_count; // [R05]
      end
      nxt_emit = rollover && cycle_start_generator_enable_ff && phy_is_root; // [R04]
   end

   // Packet gating; the two receive flags are independent
   // PHY packets also need the request context to be running
   // Identity packets ignore the PHY flag entirely
   always_comb
   begin
      nxt_phy_deliver = rx_phy_packet_valid && phy_packet_receive_enable_ff
         && ar_request_context_enabled; // [R10]
      nxt_ident_accept = rx_identity_packet_valid
         && identity_packet_receive_enable_ff; // [R11] [R12]
   end

   // State registers
   // Reset is synchronous; every register starts from zero
   // The flags have no defined power-up value, zero is the safe choice
   // Zero flags mean no counting, no emission and no packet delivery
   // The synchroniser is flushed too, so no false pin edge follows reset
   // One reset clock clears all three synchroniser stages
   // The accumulator restarts at zero, so the first tick phase is fixed
   // Read data also clears, a read before any write returns zero
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         rollover_source_select_ff <= 1'b0;
         cycle_start_generator_enable_ff <= 1'b0;
         offset_counting_enable_ff <= 1'b0;
         phy_packet_receive_enable_ff <= 1'b0;
         identity_packet_receive_enable_ff <= 1'b0;
         overlong_prev_ff <= 1'b0;
         ext_sync_ff <= 3'h0;
         ext_level_ff <= 1'b0;
         tick_acc_ff <= '0;
         offset_ff <= '0;
         count_ff <= '0;
         emit_ff <= 1'b0;
         phy_deliver_ff <= 1'b0;
         ident_accept_ff <= 1'b0;
         rd_data_ff <= '0;
      end
      else
      begin
         rollover_source_select_ff <= nxt_rollover_source_select;
         cycle_start_generator_enable_ff <= nxt_cycle_start_generator_enable;
         offset_counting_enable_ff <= nxt_offset_counting_enable;
         phy_packet_receive_enable_ff <= nxt_phy_packet_receive_enable;
         identity_packet_receive_enable_ff <= nxt_identity_packet_receive_enable;
         overlong_prev_ff <= overlong_cycle_event;
         ext_sync_ff <= {ext_sync_ff[1:0], external_rollover_input};
         ext_level_ff <= nxt_ext_level;
         tick_acc_ff <= nxt_tick_acc;
         offset_ff <= nxt_offset;
         count_ff <= nxt_count;
         emit_ff <= nxt_emit;
         phy_deliver_ff <= nxt_phy_deliver;
         ident_accept_ff <= nxt_ident_accept;
         rd_data_ff <= nxt_rd_data;
      end
   end

   // Output drive
   // Every output comes straight from a flip-flop
   // Pulses last one clock, timer values stand until they change
   // Downstream logic may sample any of them without extra staging
   assign reg_rd_data = rd_data_ff;
   assign cycle_start_emit = emit_ff;
   assign phy_packet_deliver = phy_deliver_ff;
   assign identity_packet_accept = ident_accept_ff;
   assign cycle_timer_offset = offset_ff;
   assign cycle_timer_count = count_ff;

endmodule

// [tb/lct_link_control_properties.sv]
// Port-level checks for the link control flags and cycle timer
`include "lct_regs.svh"
module lct_link_control_properties
   import lct_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [`LCT_ADDR_W-1:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [31:0] reg_wr_data,
   input wire logic reg_rd_en,
   input wire logic [31:0] reg_rd_data,
   input wire logic phy_is_root,
   input wire logic overlong_cycle_event,
   input wire logic rx_cycle_start_valid,
   input wire logic rx_phy_packet_valid,
   input wire logic ar_request_context_enabled,
   input wire logic rx_identity_packet_valid,
   input wire logic cycle_start_emit,
   input wire logic phy_packet_deliver,
   input wire logic identity_packet_accept,
   input wire logic [`LCT_OFFSET_W-1:0] cycle_timer_offset,
   input wire logic [`LCT_COUNT_W-1:0] cycle_timer_count
);
   // One clock domain, so one default clock and disable
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   reserved_zero_a: assert property (reg_rd_en |=> (reg_rd_data & ~`LCT_FLAG_MASK) == 32'h0)
      else $error("reserved bits read nonzero");
   emit_root_a: assert property (cycle_start_emit |-> $past(phy_is_root) && cycle_timer_offset == 12'h000)
      else $error("cycle start without root or rollover");
   phy_deliver_a: assert property (phy_packet_deliver |-> $past(rx_phy_packet_valid && ar_request_context_enabled))
      else $error("PHY packet delivered without cause");
   ident_accept_a: assert property (identity_packet_accept |-> $past(rx_identity_packet_valid))
      else $error("identity packet accepted without cause");
   // A resync load may move the timer anywhere; otherwise only step or wrap
   offset_step_a: assert property ($changed(cycle_timer_offset) |-> cycle_timer_offset == $past(cycle_timer_offset) + 12'h001 || cycle_timer_offset == 12'h000 || $past(rx_cycle_start_valid))
      else $error("offset jumped");
   count_step_a: assert property ($changed(cycle_timer_count) |-> (cycle_timer_count == $past(cycle_timer_count) + 13'h0001 && cycle_timer_offset == 12'h000) || $past(rx_cycle_start_valid))
      else $error("count moved without rollover");
   offset_hold_a: assert property (reg_wr_en && reg_addr == `LCT_CLR_OFFSET && reg_wr_data[20] |=> ##1 $stable(cycle_timer_offset) [*4])
      else $error("offset counted while disabled");
   overlong_block_a: assert property ($past(overlong_cycle_event) && overlong_cycle_event && reg_rd_en |=> !reg_rd_data[21])
      else $error("generator flag set during overlong event");
   set_alias_a: assert property (reg_wr_en && reg_addr == `LCT_SET_OFFSET && reg_wr_data[20] ##1 reg_rd_en && reg_addr == `LCT_SET_OFFSET |=> reg_rd_data[20])
      else $error("set alias did not set");
endmodule
bind lct_link_control lct_link_control_properties props (.*);

// [tb/lct_phy_model.sv]
// Behavioural PHY side: root report, rollover pin and received packets
module lct_phy_model
   import lct_pkg::*;
(
   input wire logic ref_clk,
   output logic external_rollover_input,
   output logic phy_is_root,
   output logic rx_cycle_start_valid,
   output logic [11:0] rx_cycle_start_offset,
   output logic [12:0] rx_cycle_start_count,
   output logic rx_phy_packet_valid,
   output logic rx_identity_packet_valid
);
   timeunit 1ns;
   timeprecision 100ps;
   // Idle strobes low; carried values are junk while not valid
   initial
   begin
      external_rollover_input = 1'b0;
      phy_is_root = 1'b1; // Node reports root
      rx_cycle_start_valid = 1'b0;
      rx_cycle_start_offset = 12'hFFF;
      rx_cycle_start_count = 13'h1FFF;
      rx_phy_packet_valid = 1'b0;
      rx_identity_packet_valid = 1'b0;
   end
   // Strobe: 0 PHY packet, 1 identity packet, one cycle each; else pin held high three cycles
   task automatic pulse(input int kind);
      @(posedge ref_clk);
      #1;
      case (kind)
         0: rx_phy_packet_valid = 1'b1;
         1: rx_identity_packet_valid = 1'b1;
         default: external_rollover_input = 1'b1;
      endcase
      // Pin level must outlast the synchroniser's two-stage agreement
      if (kind > 1)
         repeat (2) @(posedge ref_clk);
      @(posedge ref_clk);
      #1;
      rx_phy_packet_valid = 1'b0;
      rx_identity_packet_valid = 1'b0;
      external_rollover_input = 1'b0;
   endtask
   // Cycle start from another master; values inverted once released
   task automatic sync(input logic [11:0] o, input logic [12:0] c);
      @(posedge ref_clk);
      #1;
      rx_cycle_start_valid = 1'b1;
      rx_cycle_start_offset = o;
      rx_cycle_start_count = c;
      @(posedge ref_clk);
      #1;
      rx_cycle_start_valid = 1'b0;
      rx_cycle_start_offset = ~o;
      rx_cycle_start_count = ~c;
   endtask
endmodule

// [tb/tb.sv]
// Testbench for the link control registers, cycle timer and packet gates
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr_en = 1'b0;
   logic [31:0] reg_wr_data = 32'h0;
   logic reg_rd_en = 1'b0;
   logic ar_request_context_enabled = 1'b0;
   logic overlong_cycle_event = 1'b0;
   logic [31:0] reg_rd_data;
   logic external_rollover_input, phy_is_root, rx_cycle_start_valid, rx_phy_packet_valid;
   logic rx_identity_packet_valid, cycle_start_emit, phy_packet_deliver, identity_packet_accept;
   logic [11:0] rx_cycle_start_offset, cycle_timer_offset, o;
   logic [12:0] rx_cycle_start_count, cycle_timer_count, c;
   int miscompares = 0;
   int checked = 0;
   int n;
   lct_link_control dut (.*);
   lct_phy_model phy (.*);
   // Free-running clock and a hang guard well past the two cycle waits
   initial
   forever #5 ref_clk = ~ref_clk;
   initial
   begin
      #600us;
      miscompares++;
      summarize();
   end
   task automatic summarize();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask
   // Strobes held across exactly one sampling edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr = a;
      reg_wr_data = d;
      reg_wr_en = 1'b1;
      cyc(1);
      reg_wr_en = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      reg_addr = a;
      reg_rd_en = 1'b1;
      cyc(1);
      reg_rd_en = 1'b0;
      chk(reg_rd_data, exp);
   endtask
   task automatic pk(input int kind, input logic exp);
      phy.pulse(kind);
      chk({31'h0, kind == 0 ? phy_packet_deliver : identity_packet_accept}, {31'h0, exp});
   endtask
   // Bounded wait for a cycle start; n is cycles waited
   task automatic wait_emit(output int n);
      n = 0;
      do
      begin
         cyc(1);
         n++;
      end
      while (cycle_start_emit !== 1'b1 && n < 14000);
   endtask
   // Main sequence
   initial
   begin
      cyc(4);
      rst = 1'b0;
      rd(8'hE0, 32'h0); // Clear after reset
      wr(8'hE0, 32'hFFFF_FFFF); // Identity pointer taken as loaded
      rd(8'hE4, 32'h0070_0600); // Only flags stick
      rd(8'h10, 32'h0); // Unmapped place reads zero
      ar_request_context_enabled = 1'b1;
      pk(0, 1'b1); // Delivered
      ar_request_context_enabled = 1'b0;
      pk(0, 1'b0); // Context off blocks it
      pk(1, 1'b1); // Accepted
      wr(8'hE4, 32'h0000_0400);
      pk(1, 1'b1); // PHY flag off leaves identity
      wr(8'hE4, 32'h0000_0200);
      pk(1, 1'b0); // Refused
      wr(8'hE4, 32'h0050_0000);
      cyc(2);
      o = cycle_timer_offset;
      cyc(20);
      chk({20'h0, cycle_timer_offset}, {20'h0, o}); // Offset holds
      wr(8'hE0, 32'h0010_0000);
      rd(8'hE0, 32'h0030_0000); // Set alias
      cyc(20);
      chk({31'h0, cycle_timer_offset == o}, 32'h0); // Offset moves
      wait_emit(n);
      c = cycle_timer_count;
      wait_emit(n);
      chk(32'(n), 32'd12500); // 3072 ticks at 24.576 MHz
      chk({7'h0, cycle_timer_count, cycle_timer_offset}, {7'h0, c + 13'h1, 12'h0});
      overlong_cycle_event = 1'b1;
      cyc(1);
      rd(8'hE0, 32'h0010_0000); // Generator dropped
      wr(8'hE0, 32'h0020_0000);
      rd(8'hE0, 32'h0010_0000); // Set refused meanwhile
      overlong_cycle_event = 1'b0;
      wr(8'hE0, 32'h0020_0000);
      rd(8'hE0, 32'h0030_0000); // Set works again
      wr(8'hE4, 32'h0020_0000);
      phy.sync(12'h123, 13'h0055);
      chk({7'h0, cycle_timer_count, cycle_timer_offset}, {7'h0, 13'h0055, 12'h123});
      wr(8'hE0, 32'h0040_0000);
      c = cycle_timer_count;
      phy.pulse(2);
      cyc(6);
      chk({19'h0, cycle_timer_count}, {19'h0, c + 13'h1}); // Pin edge rolls over
      summarize();
   end
endmodule
